/* src/tape_load_params.svh */
// constants for the tape load sequencer: offsets, fields, timing
`ifndef TAPE_LOAD_PARAMS_SVH
`define TAPE_LOAD_PARAMS_SVH

`define CLK_KHZ          10000
`define TMR_W            26
`define NUM_TMR          9

// delay figures in milliseconds
`define TENSION_MS       500
`define SERVO_MS         50
`define VACUUM_MS        200
`define FAULT_MS         2000
`define SETTLE_MS        500
`define SEARCH_MS        3900
`define AT_MARKER_MS     100
`define RWD_START_MS     100
`define MT_TENSION_MS    500

// cycle counts derived from the figures and the clock rate
`define TENSION_CYC      (`TENSION_MS * `CLK_KHZ)
`define SERVO_CYC        (`SERVO_MS * `CLK_KHZ)
`define VACUUM_CYC       (`VACUUM_MS * `CLK_KHZ)
`define FAULT_CYC        (`FAULT_MS * `CLK_KHZ)
`define SETTLE_CYC       (`SETTLE_MS * `CLK_KHZ)
`define SEARCH_CYC       (`SEARCH_MS * `CLK_KHZ)
`define AT_MARKER_CYC    (`AT_MARKER_MS * `CLK_KHZ)
`define RWD_START_CYC    (`RWD_START_MS * `CLK_KHZ)
`define MT_TENSION_CYC   (`MT_TENSION_MS * `CLK_KHZ)

// register byte offsets
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_LIMIT_BASE   8'h10
`define REG_LIMIT_LAST   8'h30

// field positions
`define CTRL_DOUBLE      0
`define CTRL_RESET_RDY   1
`define ST_PHASE_A       0
`define ST_FWD_SEARCH    1
`define ST_RWD_REQ       2
`define ST_RWD_ARM       3
`define ST_RWD_STOP      4
`define ST_MIDTAPE       5
`define ST_ONLINE        6
`define ST_FAULT         7
`define ST_VAC_RUN       8
`define ST_COLS_READY    9

`endif

/* src/tape_load_pkg.sv */
// types shared by the tape load sequencer files
`include "tape_load_params.svh"
package tape_load_pkg;
    typedef logic [`TMR_W-1:0] count_t;
    typedef enum logic [3:0] {
        TMR_TENSION    = 4'h0,
        TMR_SERVO      = 4'h1,
        TMR_VACUUM     = 4'h2,
        TMR_FAULT      = 4'h3,
        TMR_SETTLE     = 4'h4,
        TMR_SEARCH     = 4'h5,
        TMR_AT_MARKER  = 4'h6,
        TMR_RWD_START  = 4'h7,
        TMR_MT_TENSION = 4'h8
    } timer_id_e;
endpackage : tape_load_pkg

/* src/delay_timer.sv */
// restartable delay counter: done rises limit cycles after run rises
`timescale 1ns/100ps
module delay_timer
    import tape_load_pkg::*;
(
    input  wire logic   core_clk_in,
    input  wire logic   rst_n_in,
    input  wire logic   run_in,
    input  wire count_t limit_in,
    output logic        done_out
);
    count_t cnt_q;

    // dropping run clears the count so each start times afresh
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q    <= '0;
            done_out <= 1'b0;
        end
        else if (!run_in)
        begin
            cnt_q    <= '0;
            done_out <= 1'b0;
        end
        else if (!done_out)
        begin
            cnt_q    <= count_t'(cnt_q + 1'b1);
            done_out <= (count_t'(cnt_q + 1'b1) >= limit_in);
        end
    end
endmodule : delay_timer

/* src/tape_load_sequencer.sv */
// tape load sequencer: column load, marker search, rewind recovery
//
// Overview of operation
// - load press gives a pulse; its falling edge starts the column load
// - single load search waits for the interlock switches to close; second press and refind do not check them
// - column load start runs the half second tension timer
// - tension request runs servo relay timer; relay energizes on expiry
// - tension expiry drops request and runs vacuum relay timer to relay
// - vacuum sensed, vacuum timer done, interlock open: ready, fault delay
// - interlock still open at fault delay end: fault resets the load
// - interlock closing in time holds servo relay and starts settle timer
// - settle expiry gives hold done, which ends the column load phase
// - single load: phase end starts forward search and on-line ready
// - double load: second press with on-line ready starts the search
// - marker rising before search expiry clears search and ends load
// - search expiry requests rewind; arm clears search, starts rewind timer
// - rewind timer expiry starts rewind ramp and drops the limit relay
// - ramp at threshold gives reverse drive and the return relay
// - marker falling in rewind stops ramp and drops return relay
// - reverse drive dropping outside column load restarts forward search
// - marker after rewind clears request, search, then stop and arm
// - search start runs at marker timer; marker present ends load early
// - mid-tape low pulse starts mid-tape load with tension and servo
// - mid-tape tension expiry drops request and runs the vacuum relay
// - mid-tape interlock closure settles, then clears the mid-tape load
`timescale 1ns/100ps
module tape_load_sequencer
    import tape_load_pkg::*;
#(
    parameter count_t TENSION_CYC    = count_t'(`TENSION_CYC),
    parameter count_t SERVO_CYC      = count_t'(`SERVO_CYC),
    parameter count_t VACUUM_CYC     = count_t'(`VACUUM_CYC),
    parameter count_t FAULT_CYC      = count_t'(`FAULT_CYC),
    parameter count_t SETTLE_CYC     = count_t'(`SETTLE_CYC),
    parameter count_t SEARCH_CYC     = count_t'(`SEARCH_CYC),
    parameter count_t AT_MARKER_CYC  = count_t'(`AT_MARKER_CYC),
    parameter count_t RWD_START_CYC  = count_t'(`RWD_START_CYC),
    parameter count_t MT_TENSION_CYC = count_t'(`MT_TENSION_CYC)
)
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        load_switch_in,
    input  wire logic        vacuum_sense_in,
    input  wire logic        interlock_closed_in,
    input  wire logic        marker_in,
    input  wire logic        midtape_load_n_in,
    input  wire logic        ramp_at_level_in,
    output logic             tension_request_out,
    output logic             servo_relay_out,
    output logic             vacuum_relay_out,
    output logic             columns_ready_out,
    output logic             load_fault_out,
    output logic             interlock_held_out,
    output logic             online_ready_out,
    output logic             forward_drive_out,
    output logic             rewind_ramp_on_out,
    output logic             reverse_drive_out,
    output logic             return_relay_out,
    output logic             limit_relay_out
);
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction : fell

    function automatic logic rose(input logic prev, input logic cur);
        rose = ~prev & cur;
    endfunction : rose

    function automatic count_t default_limit(input int idx);
        case (idx)
            0:       default_limit = TENSION_CYC;
            1:       default_limit = SERVO_CYC;
            2:       default_limit = VACUUM_CYC;
            3:       default_limit = FAULT_CYC;
            4:       default_limit = SETTLE_CYC;
            5:       default_limit = SEARCH_CYC;
            6:       default_limit = AT_MARKER_CYC;
            7:       default_limit = RWD_START_CYC;
            default: default_limit = MT_TENSION_CYC;
        endcase
    endfunction : default_limit

    count_t limit_q [`NUM_TMR];
    logic   run     [`NUM_TMR];
    logic   done    [`NUM_TMR];

    logic   load_button_pulse_q;
    logic   marker_q;
    logic   midtape_n_q;
    logic   reverse_q;
    logic   request_prev_q;
    logic   load_phase_a_q;
    logic   forward_search_state_q;
    logic   rewind_search_request_q;
    logic   rewind_arm_q;
    logic   rewind_stop_q;
    logic   rewind_clear_q;
    logic   midtape_load_state_q;
    logic   online_ready_q;
    logic   vac_run_q;
    logic   cols_ready_q;
    logic   fault_seen_q;
    logic   double_load_q;
    logic   ack_q;

    logic   idle;
    logic   button_fall;
    logic   second_press;
    logic   tension_request;
    logic   vacuum_relay;
    logic   interlock_held;
    logic   load_fault;
    logic   hold_done;
    logic   load_done_clear;
    logic   search_clear;
    logic   search_timeout;
    logic   arm_rise;
    logic   refind;
    logic   reverse_drive;
    logic   rewind_ramp_on;
    logic   bus_req;
    logic   wr_take;
    logic   limit_hit;
    logic [3:0] limit_idx;
    logic [31:0] status;

    for (genvar i = 0; i < `NUM_TMR; i++)
    begin : g_tmr
        delay_timer u_tmr (
            .core_clk_in (core_clk_in),
            .rst_n_in    (rst_n_in),
            .run_in      (run[i]),
            .limit_in    (limit_q[i]),
            .done_out    (done[i])
        );
    end

    assign button_fall  = fell(load_button_pulse_q, load_switch_in);
    assign idle         = ~load_phase_a_q & ~midtape_load_state_q
                        & ~forward_search_state_q & ~rewind_arm_q;
    assign second_press = button_fall & idle & double_load_q
                        & online_ready_q;

    assign tension_request = (load_phase_a_q & ~done[TMR_TENSION])
                           | (midtape_load_state_q & ~done[TMR_MT_TENSION]);
    assign vacuum_relay    = vac_run_q & done[TMR_VACUUM];
    assign interlock_held  = interlock_closed_in & vacuum_relay
                           & (load_phase_a_q | midtape_load_state_q);
    assign load_fault      = load_phase_a_q & done[TMR_FAULT]
                           & ~interlock_closed_in;
    assign hold_done       = done[TMR_SETTLE]
                           & (load_phase_a_q | midtape_load_state_q);
    assign load_done_clear = hold_done & midtape_load_state_q;

    assign search_clear   = forward_search_state_q
                          & ((rose(marker_q, marker_in)
                              & ~done[TMR_SEARCH])
                             | (done[TMR_AT_MARKER] & marker_in));
    assign search_timeout = forward_search_state_q & done[TMR_SEARCH]
                          & ~search_clear;
    assign arm_rise       = rewind_search_request_q & ~request_prev_q;

    assign reverse_drive  = ramp_at_level_in & rewind_arm_q;
    assign refind         = rewind_stop_q & fell(reverse_q, reverse_drive)
                          & ~load_phase_a_q;
    assign rewind_ramp_on = rewind_arm_q & ~rewind_stop_q
                          & done[TMR_RWD_START];

    // timer run terms
    // tension timer
    assign run[TMR_TENSION]    = load_phase_a_q;
    assign run[TMR_SERVO]      = tension_request;
    assign run[TMR_VACUUM]     = vac_run_q;
    assign run[TMR_FAULT]      = cols_ready_q & load_phase_a_q
                               & ~interlock_held;
    assign run[TMR_SETTLE]     = interlock_held & ~hold_done;
    assign run[TMR_SEARCH]     = forward_search_state_q;
    assign run[TMR_AT_MARKER]  = forward_search_state_q;
    assign run[TMR_RWD_START]  = rewind_arm_q & ~rewind_stop_q;
    assign run[TMR_MT_TENSION] = midtape_load_state_q;

    // input and internal state sampling for edge detection
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            load_button_pulse_q <= 1'b0;
            marker_q            <= 1'b0;
            midtape_n_q         <= 1'b1;
            reverse_q           <= 1'b0;
            request_prev_q      <= 1'b0;
        end
        else
        begin
            load_button_pulse_q <= load_switch_in;
            marker_q            <= marker_in;
            midtape_n_q         <= midtape_load_n_in;
            reverse_q           <= reverse_drive;
            request_prev_q      <= rewind_search_request_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            load_phase_a_q <= 1'b0;
        else if (load_fault || (hold_done && load_phase_a_q))
            load_phase_a_q <= 1'b0;
        else if (button_fall && idle && !second_press)
            load_phase_a_q <= 1'b1;
    end

    // clear wins here: a marker hit and a restart never coincide usefully
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            forward_search_state_q <= 1'b0;
        else if (search_clear || arm_rise)
            forward_search_state_q <= 1'b0;
        else if ((hold_done && load_phase_a_q && !double_load_q)
                 || second_press || refind)
            forward_search_state_q <= 1'b1;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            online_ready_q <= 1'b0;
        else if (hold_done && load_phase_a_q)
            online_ready_q <= 1'b1;
        else if (wr_take && avs_address_in == `REG_CTRL
                 && avs_writedata_in[`CTRL_RESET_RDY])
            online_ready_q <= 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rewind_search_request_q <= 1'b0;
        else if (search_timeout)
            rewind_search_request_q <= 1'b1;
        else if (search_clear)
            rewind_search_request_q <= 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rewind_arm_q <= 1'b0;
        else if (arm_rise)
            rewind_arm_q <= 1'b1;
        else if (rewind_clear_q)
            rewind_arm_q <= 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rewind_stop_q <= 1'b0;
        else if (rewind_arm_q && reverse_drive
                 && fell(marker_q, marker_in))
            rewind_stop_q <= 1'b1;
        else if (rewind_clear_q)
            rewind_stop_q <= 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rewind_clear_q <= 1'b0;
        else
            rewind_clear_q <= search_clear & rewind_arm_q;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            midtape_load_state_q <= 1'b0;
        else if (load_done_clear)
            midtape_load_state_q <= 1'b0;
        else if (fell(midtape_n_q, midtape_load_n_in) && idle
                 && !button_fall)
            midtape_load_state_q <= 1'b1;
    end

    // vacuum stays on after an off-line load; only a fault or the
    // end of a mid-tape load drops it
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            vac_run_q <= 1'b0;
        else if (load_fault || load_done_clear)
            vac_run_q <= 1'b0;
        else if ((load_phase_a_q && done[TMR_TENSION])
                 || (midtape_load_state_q && done[TMR_MT_TENSION]))
            vac_run_q <= 1'b1;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cols_ready_q <= 1'b0;
        else if (!load_phase_a_q || load_fault)
            cols_ready_q <= 1'b0;
        else if (vacuum_sense_in && vacuum_relay && !interlock_closed_in)
            cols_ready_q <= 1'b1;
    end

    // sticky fault flag: a new fault wins over a software clear
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            fault_seen_q <= 1'b0;
        else if (load_fault)
            fault_seen_q <= 1'b1;
        else if (wr_take && avs_address_in == `REG_STATUS
                 && avs_writedata_in[`ST_FAULT])
            fault_seen_q <= 1'b0;
    end

    // bus slave: one wait cycle, write lands on the released edge
    assign bus_req             = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~ack_q;
    assign wr_take             = avs_write_in & ack_q;
    assign limit_hit           = avs_address_in >= `REG_LIMIT_BASE
                               && avs_address_in <= `REG_LIMIT_LAST
                               && avs_address_in[1:0] == 2'h0;
    assign limit_idx           = 4'(avs_address_in[7:2]
                                    - 6'(`REG_LIMIT_BASE >> 2));

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ack_q <= 1'b0;
        else
            ack_q <= bus_req & ~ack_q;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            double_load_q <= 1'b0;
        else if (wr_take && avs_address_in == `REG_CTRL)
            double_load_q <= avs_writedata_in[`CTRL_DOUBLE];
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < `NUM_TMR; i++)
                limit_q[i] <= default_limit(i);
        end
        else if (wr_take && limit_hit)
            limit_q[limit_idx] <= avs_writedata_in[`TMR_W-1:0];
    end

    always_comb
    begin
        status                 = '0;
        status[`ST_PHASE_A]    = load_phase_a_q;
        status[`ST_FWD_SEARCH] = forward_search_state_q;
        status[`ST_RWD_REQ]    = rewind_search_request_q;
        status[`ST_RWD_ARM]    = rewind_arm_q;
        status[`ST_RWD_STOP]   = rewind_stop_q;
        status[`ST_MIDTAPE]    = midtape_load_state_q;
        status[`ST_ONLINE]     = online_ready_q;
        status[`ST_FAULT]      = fault_seen_q;
        status[`ST_VAC_RUN]    = vac_run_q;
        status[`ST_COLS_READY] = cols_ready_q;
    end

    // read data captured in the wait cycle, standing at the release
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (avs_read_in && !ack_q)
        begin
            if (avs_address_in == `REG_CTRL)
                avs_readdata_out <= {31'h0, double_load_q};
            else if (avs_address_in == `REG_STATUS)
                avs_readdata_out <= status;
            else if (limit_hit)
                avs_readdata_out <= {6'h00, limit_q[limit_idx]};
            else
                avs_readdata_out <= 32'h0000_0000;
        end
    end

    assign tension_request_out = tension_request;
    assign servo_relay_out     = (tension_request & done[TMR_SERVO])
                               | (interlock_closed_in & vacuum_relay)
                               | (vacuum_relay & (forward_search_state_q
                                                  | rewind_arm_q));
    assign vacuum_relay_out    = vacuum_relay;
    assign columns_ready_out   = cols_ready_q;
    assign load_fault_out      = load_fault;
    assign interlock_held_out  = interlock_held;
    assign online_ready_out    = online_ready_q;
    assign forward_drive_out   = forward_search_state_q;
    assign rewind_ramp_on_out  = rewind_ramp_on;
    assign reverse_drive_out   = reverse_drive;
    assign return_relay_out    = reverse_drive & ~rewind_stop_q;
    assign limit_relay_out     = ~rewind_ramp_on;
endmodule : tape_load_sequencer

/* test/tape_load_sequencer_checker.sv */
// port assertions for the tape load sequencer
`timescale 1ns/100ps
module tape_load_sequencer_checker
(
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic tension_request_out,
    input  wire logic servo_relay_out,
    input  wire logic vacuum_relay_out,
    input  wire logic load_fault_out,
    input  wire logic interlock_held_out,
    input  wire logic interlock_closed_in,
    input  wire logic forward_drive_out,
    input  wire logic rewind_ramp_on_out,
    input  wire logic reverse_drive_out,
    input  wire logic return_relay_out,
    input  wire logic limit_relay_out,
    input  wire logic marker_in
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    limit_relay_a: assert property (
        limit_relay_out == !rewind_ramp_on_out)
        else $error("limit relay wrong");
    return_relay_a: assert property (
        $rose(reverse_drive_out) |-> return_relay_out)
        else $error("return relay off");
    search_gate_a: assert property (
        $rose(forward_drive_out) |-> interlock_closed_in)
        else $error("search before interlock");
    vacuum_order_a: assert property (
        $rose(vacuum_relay_out) |-> !tension_request_out)
        else $error("vacuum while tensioning");
    fault_cause_a: assert property (
        $rose(load_fault_out) |-> !interlock_closed_in)
        else $error("fault with interlock closed");
    held_servo_a: assert property (
        interlock_held_out |-> servo_relay_out)
        else $error("servo off while held");
    servo_delay_a: assert property (
        $rose(tension_request_out) |-> ##[1:12] servo_relay_out)
        else $error("servo relay late");
    marker_stop_a: assert property (
        $rose(marker_in) && forward_drive_out |-> ##[1:3] !forward_drive_out)
        else $error("drive kept after marker");
endmodule : tape_load_sequencer_checker

/* test/tape_deck_model.sv */
// far side model: vacuum sense, column interlock, rewind ramp level
`timescale 1ns/100ps
module tape_deck_model
(
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic vacuum_relay_in,
    input  wire logic rewind_ramp_on_in,
    input  wire logic close_ok_in,
    output logic      vacuum_sense_out,
    output logic      interlock_closed_out,
    output logic      ramp_at_level_out
);
    logic [2:0] vac_q;
    logic [2:0] ramp_q;
    // vacuum and ramp lag their causes, as a real blower and slew would
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vac_q <= 3'h0;
            ramp_q <= 3'h0;
            interlock_closed_out <= 1'b0;
        end
        else
        begin
            vac_q <= {vac_q[1:0], vacuum_relay_in};
            ramp_q <= {ramp_q[1:0], rewind_ramp_on_in};
            if (!vacuum_relay_in)
                interlock_closed_out <= 1'b0;
            else if (vac_q[2] && close_ok_in)
                interlock_closed_out <= 1'b1;
        end
    end
    assign vacuum_sense_out = vac_q[2];
    assign ramp_at_level_out = ramp_q[2];
endmodule : tape_deck_model

/* test/tape_load_sequencer_tb.sv */
// self-checking bench for the tape load sequencer
`timescale 1ns/100ps
module tape_load_sequencer_tb;
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0;
    logic avs_write_in = 1'b0, load_switch_in = 1'b0, marker_in = 1'b0;
    logic midtape_load_n_in = 1'b1, close_ok = 1'b1;
    logic [7:0] avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic avs_waitrequest_out, vacuum_sense_in, interlock_closed_in;
    logic ramp_at_level_in, tension_request_out, servo_relay_out;
    logic vacuum_relay_out, columns_ready_out, load_fault_out;
    logic interlock_held_out, online_ready_out, forward_drive_out;
    logic rewind_ramp_on_out, reverse_drive_out, return_relay_out;
    logic limit_relay_out;
    integer fail_count = 0, n_checks = 0, seed = 32'h3ac5;
    wire [7:0] obs = {tension_request_out, online_ready_out, vacuum_relay_out,
        interlock_held_out, load_fault_out, reverse_drive_out,
        rewind_ramp_on_out, forward_drive_out};
    tape_load_sequencer #(.TENSION_CYC(26'd20), .SEARCH_CYC(26'd80),
        .AT_MARKER_CYC(26'd8), .RWD_START_CYC(26'd8),
        .MT_TENSION_CYC(26'd20)) u_tape_load_sequencer (.*);
    tape_deck_model u_tape_deck_model (.core_clk_in, .rst_n_in,
        .vacuum_relay_in(vacuum_relay_out),
        .rewind_ramp_on_in(rewind_ramp_on_out), .close_ok_in(close_ok),
        .vacuum_sense_out(vacuum_sense_in),
        .interlock_closed_out(interlock_closed_in),
        .ramp_at_level_out(ramp_at_level_in));
    always #50 core_clk_in = ~core_clk_in;
    task summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : tick
    task chk(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk32
    task wait_bit(input int i, input logic v);
        int k;
        for (k = 0; k < 3000; k++)
        begin
            @(negedge core_clk_in);
            if (obs[i] === v) break;
        end
        if (k == 3000)
        begin
            $display("unexpected wait %0d: expected %b seen %b", i, v, obs[i]);
            fail_count++;
            summarize();
        end
    endtask : wait_bit
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !we;
        avs_write_in <= we;
        for (k = 0; k < 100; k++)
        begin
            @(posedge core_clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (k == 100)
        begin
            fail_count++;
            summarize();
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus
    task press();
        @(posedge core_clk_in);
        load_switch_in <= 1'b1;
        tick(2 + ($random(seed) & 3));
        load_switch_in <= 1'b0;
    endtask : press
    task restart();
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        tick(7);
        rst_n_in <= 1'b1;
        for (int i = 1; i < 5; i++)
            bus(1'b1, 8'h10 + 8'(i * 4), 32'd10);
    endtask : restart
    initial
    begin
        restart();
        @(negedge core_clk_in);
        chk("limit_relay", 1'b1, limit_relay_out);
        chk("online_ready", 1'b0, online_ready_out);
        bus(1'b0, 8'h04, 32'h0);
        chk32("status", 32'h0, rd);
        bus(1'b1, 8'h3c, 32'hffffffff);
        bus(1'b0, 8'h3c, 32'h0);
        chk32("unmapped", 32'h0, rd);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk32("ctrl", 32'h1, rd);
        press();
        wait_bit(4, 1'b1);
        chk("servo_relay", 1'b1, servo_relay_out);
        wait_bit(6, 1'b1);
        chk("forward_drive", 1'b0, forward_drive_out);
        press();
        wait_bit(0, 1'b1);
        $display("test double load done");
        restart();
        press();
        wait_bit(0, 1'b1);
        chk("online_ready", 1'b1, online_ready_out);
        tick(1 + ($random(seed) & 7));
        marker_in <= 1'b1;
        wait_bit(0, 1'b0);
        $display("test single load done");
        restart();
        marker_in <= 1'b0;
        close_ok <= 1'b0;
        press();
        wait_bit(3, 1'b1);
        chk("columns_ready", 1'b1, columns_ready_out);
        tick(2);
        bus(1'b0, 8'h04, 32'h0);
        chk32("fault status", 32'h80, rd & 32'h81);
        $display("test load fault done");
        restart();
        close_ok <= 1'b1;
        marker_in <= 1'b1;
        press();
        wait_bit(0, 1'b1);
        wait_bit(0, 1'b0);
        tick(10);
        chk("no rewind", 1'b0, rewind_ramp_on_out);
        $display("test load at marker done");
        restart();
        marker_in <= 1'b0;
        press();
        wait_bit(0, 1'b1);
        wait_bit(1, 1'b1);
        chk("forward_drive", 1'b0, forward_drive_out);
        chk("limit_relay", 1'b0, limit_relay_out);
        wait_bit(2, 1'b1);
        chk("return_relay", 1'b1, return_relay_out);
        @(posedge core_clk_in);
        marker_in <= 1'b1;
        tick(2);
        marker_in <= 1'b0;
        wait_bit(1, 1'b0);
        chk("return_relay", 1'b0, return_relay_out);
        wait_bit(0, 1'b1);
        @(posedge core_clk_in);
        marker_in <= 1'b1;
        wait_bit(0, 1'b0);
        tick(3);
        bus(1'b0, 8'h04, 32'h0);
        chk32("rewind status", 32'h0, rd & 32'h1c);
        $display("test rewind load done");
        restart();
        marker_in <= 1'b0;
        midtape_load_n_in <= 1'b0;
        tick(2);
        midtape_load_n_in <= 1'b1;
        wait_bit(7, 1'b1);
        wait_bit(4, 1'b1);
        tick(20);
        bus(1'b0, 8'h04, 32'h0);
        chk32("midtape status", 32'h0, rd & 32'h20);
        chk("vacuum_relay", 1'b0, vacuum_relay_out);
        $display("test mid-tape load done");
        summarize();
    end
endmodule : tape_load_sequencer_tb
bind tape_load_sequencer tape_load_sequencer_checker
    u_tape_load_sequencer_checker (.*);
